// File: include/saft_cfg.svh
`ifndef SAFT_CFG_SVH
`define SAFT_CFG_SVH
`define SAFT_ADDR_SYS 5'h00
`define SAFT_ADDR_FRAME 5'h04
`define SAFT_ADDR_CLAMP 5'h08
`define SAFT_ADDR_ANGLE 5'h0c
`define SAFT_ADDR_STAT 5'h10
`define SAFT_SYS_SENT_EN 12
`define SAFT_FS_TICK_LSB 0
`define SAFT_FS_CRC_REC 2
`define SAFT_FS_PAUSE_EN 3
`define SAFT_FS_LEN_FIX 4
`define SAFT_FS_FMT_LSB 5
`define SAFT_FS_FALLING 7
`define SAFT_FS_SLOW_EN 8
`define SAFT_FS_NO_WARN 9
`define SAFT_FS_NO_DIAG 10
`define SAFT_SYS_RST 32'h0000_0000
`define SAFT_FS_RST 32'h0000_0025
`define SAFT_CLAMP_RST 32'h0001_0ff8
`define SAFT_ANGLE_RST 32'h0ffc_0ff8
`define SAFT_CLK_MHZ 200
`define SAFT_TICK0_US_X10 27
`define SAFT_TICK1_US_X10 30
`define SAFT_TICK2_US_X10 45
`define SAFT_TICK3_US_X10 60
`define SAFT_TICK_CYC(t) (((t) * `SAFT_CLK_MHZ + 9) / 10)
`define SAFT_SYNC_TICKS 9'd56
`define SAFT_NIB_BASE 9'd12
`define SAFT_LOW_TICKS 9'd5
`define SAFT_PAUSE_MIN 9'd12
`define SAFT_LEN_DUAL 9'd239
`define SAFT_LEN_SS 9'd269
`define SAFT_LEN_HS 9'd196
`define SAFT_LEN_FIX 9'd297
`define SAFT_CRC_SEED 4'h5
`define SAFT_CRC_POLY 5'h1d
`define SAFT_NEW_MIN 12'h001
`define SAFT_NEW_MAX 12'hff8
`define SAFT_VAL_FULL 12'hfff
`endif

// File: include/saft_pkg.sv
package saft_pkg;
`include "saft_cfg.svh"
  typedef enum logic [1:0] {SAFT_IDLE, SAFT_SYNC, SAFT_NIB, SAFT_PAUSE}
    saft_state_e;
  typedef enum logic [1:0] {SAFT_FMT_SS_OLD, SAFT_FMT_SS_NEW, SAFT_FMT_DUAL,
    SAFT_FMT_HS} saft_fmt_e;

  // one crc nibble step: multiply by x^4 modulo the generator, add nibble
  function automatic logic [3:0] saft_crc_step(input logic [3:0] crc,
                                               input logic [3:0] nib);
    logic [4:0] r;
    r = {1'b0, crc};
    for (int i = 0; i < 4; i++) begin
      r = {r[3:0], 1'b0};
      if (r[4]) begin
        r = r ^ `SAFT_CRC_POLY;
      end
    end
    return r[3:0] ^ nib;
  endfunction

  // byte-lane merge for avalon writes
  function automatic logic [31:0] saft_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// File: include/saft_crc_if.sv
`timescale 1ns/1ps
interface saft_crc_if;
  logic clr;
  logic step;
  logic [3:0] nib;
  logic [3:0] crc;
  modport ctl (output clr, output step, output nib, input crc);
  modport eng (input clr, input step, input nib, output crc);
endinterface

// File: verilog/saft_crc4.sv
`timescale 1ns/1ps
module saft_crc4
  import saft_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i,   // async reset, active low
  saft_crc_if.eng crc_if      // control and result
);
  logic [3:0] crc_q;

  // accumulator restarts from the seed at every frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_q <= `SAFT_CRC_SEED;
    end else if (crc_if.clr) begin
      crc_q <= `SAFT_CRC_SEED;
    end else if (crc_if.step) begin
      crc_q <= saft_crc_step(crc_q, crc_if.nib);
    end
  end

  assign crc_if.crc = crc_q;
endmodule

// File: verilog/saft_tx.sv
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module saft_tx
  import saft_pkg::*;
(
  input wire logic clk_sys_i,               // 200 MHz system clock
  input wire logic rst_n_i,                 // async reset, active low
  input wire logic [4:0] avs_address_i,     // byte address
  input wire logic avs_read_i,              // read strobe
  input wire logic avs_write_i,             // write strobe
  input wire logic [31:0] avs_writedata_i,  // write data
  input wire logic [3:0] avs_byteenable_i,  // byte lanes
  output logic [31:0] avs_readdata_o,       // read data
  output logic avs_waitrequest_o,           // stall
  input wire logic [11:0] angle_i,          // measured angle
  input wire logic diag_i,                  // diagnostic condition
  input wire logic prewarn_i,               // pre-warning condition
  input wire logic [1:0] slow_bits_i,       // slow channel bits 3..2
  output logic output_data_pin_o,           // frame waveform
  output logic output_data_pin_oe_o,        // pin driven by sent logic
  output logic frame_start_o                // pulse at each frame start
);
  // configuration words
  logic [31:0] system_settings_word;
  logic [31:0] frame_settings_word;
  logic [31:0] clamp_word;
  logic [31:0] angle_word;

  // bus handshake
  logic bus_ack;
  logic [31:0] rd_data;

  // sequencer state
  saft_state_e state;
  logic [2:0] nib_idx;
  logic [2:0] n_data_q;
  logic [3:0] nib_q [0:7];
  logic [10:0] div;
  logic [10:0] tick_cyc_q;
  logic [8:0] tick_in_el;
  logic [8:0] el_len;
  logic [8:0] frame_ticks;
  logic [8:0] frame_len_q;
  logic pause_en_q;
  logic crc_rec_q;
  logic [7:0] loop_cnt;
  logic pin_q;
  logic oe_q;
  logic start_q;

  // combinational helpers
  logic sent_en;
  saft_fmt_e fmt;
  logic falling;
  logic [11:0] clamp_hi;
  logic [11:0] clamp_lo;
  logic [11:0] max_ang;
  logic [11:0] sw_ang;
  logic [11:0] ang_val;
  logic [11:0] inv_val;
  logic [3:0] status_nib;
  logic [3:0] data_nib [0:5];
  logic [2:0] n_data;
  logic [10:0] tick_sel_cyc;
  logic [8:0] target_len;
  logic tick_end;
  logic el_end;
  logic [2:0] last_idx;
  logic is_last;
  logic start_frame;
  logic [3:0] nxt_nib;
  logic [8:0] used;
  logic [8:0] pause_len;
  logic zero_step;

  saft_crc_if crc_if();

  saft_crc4 u_crc (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .crc_if    (crc_if)
  );

  // ---- register bus
  // one wait cycle per access keeps read data registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;

  // writes land on the edge where waitrequest is low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_settings_word <= `SAFT_SYS_RST;
      frame_settings_word <= `SAFT_FS_RST;
      clamp_word <= `SAFT_CLAMP_RST;
      angle_word <= `SAFT_ANGLE_RST;
    end else if (avs_write_i & bus_ack) begin
      case (avs_address_i)
        `SAFT_ADDR_SYS: begin
          system_settings_word <= saft_merge(system_settings_word,
            avs_writedata_i, avs_byteenable_i);
        end
        `SAFT_ADDR_FRAME: begin
          frame_settings_word <= saft_merge(frame_settings_word,
            avs_writedata_i, avs_byteenable_i);
        end
        `SAFT_ADDR_CLAMP: begin
          clamp_word <= saft_merge(clamp_word, avs_writedata_i,
            avs_byteenable_i);
        end
        `SAFT_ADDR_ANGLE: begin
          angle_word <= saft_merge(angle_word, avs_writedata_i,
            avs_byteenable_i);
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (avs_address_i)
      `SAFT_ADDR_SYS: rd_data = system_settings_word;
      `SAFT_ADDR_FRAME: rd_data = frame_settings_word;
      `SAFT_ADDR_CLAMP: rd_data = clamp_word;
      `SAFT_ADDR_ANGLE: rd_data = angle_word;
      `SAFT_ADDR_STAT: begin
        rd_data = {15'h0000, oe_q, 2'h0, crc_if.crc, state, loop_cnt};
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~bus_ack) begin
      avs_readdata_o <= rd_data;
    end
  end

  // ---- configuration fields
  assign sent_en = system_settings_word[`SAFT_SYS_SENT_EN];
  assign fmt = saft_fmt_e'(frame_settings_word[`SAFT_FS_FMT_LSB +: 2]);
  assign falling = frame_settings_word[`SAFT_FS_FALLING];
  assign clamp_hi = clamp_word[11:0];
  assign clamp_lo = clamp_word[27:16];
  assign max_ang = angle_word[11:0];
  assign sw_ang = angle_word[27:16];

  // angle to data value with clamping around the maximum angle
  always_comb begin
    if (angle_i > max_ang) begin
      if (angle_i < sw_ang) begin
        ang_val = falling ? clamp_lo : clamp_hi;
      end else begin
        ang_val = falling ? clamp_hi : clamp_lo;
      end
    end else begin
      ang_val = falling ? max_ang - angle_i : angle_i;
    end
    // newer format guards the reserved codes even if clamps are wrong
    if (fmt == SAFT_FMT_SS_NEW) begin
      if (ang_val < `SAFT_NEW_MIN) begin
        ang_val = `SAFT_NEW_MIN;
      end else if (ang_val > `SAFT_NEW_MAX) begin
        ang_val = `SAFT_NEW_MAX;
      end
    end
  end

  assign inv_val = `SAFT_VAL_FULL - ang_val;

  // status nibble: slow bits, pre-warning, diagnostic
  always_comb begin
    status_nib[3:2] = frame_settings_word[`SAFT_FS_SLOW_EN] ?
      slow_bits_i : 2'b00;
    status_nib[1] = prewarn_i &
      ~frame_settings_word[`SAFT_FS_NO_WARN];
    status_nib[0] = diag_i &
      ~frame_settings_word[`SAFT_FS_NO_DIAG];
  end

  // data nibble content per protocol format, most significant first except the dual format's inverted value
  always_comb begin
    data_nib[0] = ang_val[11:8];
    data_nib[1] = ang_val[7:4];
    data_nib[2] = ang_val[3:0];
    n_data = 3'd6;
    case (fmt)
      SAFT_FMT_SS_OLD, SAFT_FMT_SS_NEW: begin
        data_nib[3] = loop_cnt[7:4];
        data_nib[4] = loop_cnt[3:0];
        data_nib[5] = ~ang_val[11:8];
      end
      SAFT_FMT_DUAL: begin
        // opposite slope value, nibble order reversed
        data_nib[3] = inv_val[3:0];
        data_nib[4] = inv_val[7:4];
        data_nib[5] = inv_val[11:8];
      end
      SAFT_FMT_HS: begin
        // high speed packs three bits per nibble into four nibbles
        data_nib[0] = {1'b0, ang_val[11:9]};
        data_nib[1] = {1'b0, ang_val[8:6]};
        data_nib[2] = {1'b0, ang_val[5:3]};
        data_nib[3] = {1'b0, ang_val[2:0]};
        data_nib[4] = 4'h0;
        data_nib[5] = 4'h0;
        n_data = 3'd4;
      end
      default: begin
        data_nib[3] = 4'h0;
        data_nib[4] = 4'h0;
        data_nib[5] = 4'h0;
      end
    endcase
  end

  // tick period select, latched per frame so a frame never changes pace
  always_comb begin
    case (frame_settings_word[`SAFT_FS_TICK_LSB +: 2])
      2'd0: tick_sel_cyc = 11'(`SAFT_TICK_CYC(`SAFT_TICK0_US_X10));
      2'd1: tick_sel_cyc = 11'(`SAFT_TICK_CYC(`SAFT_TICK1_US_X10));
      2'd2: tick_sel_cyc = 11'(`SAFT_TICK_CYC(`SAFT_TICK2_US_X10));
      default: tick_sel_cyc = 11'(`SAFT_TICK_CYC(`SAFT_TICK3_US_X10));
    endcase
  end

  // constant frame length target
  always_comb begin
    if (frame_settings_word[`SAFT_FS_LEN_FIX]) begin
      target_len = `SAFT_LEN_FIX;
    end else begin
      case (fmt)
        SAFT_FMT_DUAL: target_len = `SAFT_LEN_DUAL;
        SAFT_FMT_HS: target_len = `SAFT_LEN_HS;
        default: target_len = `SAFT_LEN_SS;
      endcase
    end
  end

  // ---- sequencing helpers
  assign tick_end = (div == tick_cyc_q - 11'd1);
  assign el_end = (state != SAFT_IDLE) & tick_end &
    (tick_in_el == el_len - 9'd1);
  assign last_idx = n_data_q + 3'd1;
  assign is_last = (nib_idx == last_idx);
  assign nxt_nib = (nib_idx + 3'd1 == last_idx) ? crc_if.crc :
    nib_q[nib_idx + 3'd1];
  assign used = frame_ticks + el_len;
  // a frame that already overruns the target still gets a short pause
  assign pause_len = (frame_len_q > used + `SAFT_PAUSE_MIN) ?
    frame_len_q - used : `SAFT_PAUSE_MIN;

  // a new frame starts back to back with the previous one
  assign start_frame = sent_en & ((state == SAFT_IDLE) | (el_end &
    ((state == SAFT_PAUSE) | (state == SAFT_NIB & is_last &
    ~pause_en_q))));

  // ---- crc control: data nibbles plus a zero nibble when recommended, status never fed in
  assign zero_step = (state == SAFT_NIB) & (nib_idx == n_data_q) &
    (tick_in_el == 9'd0) & (div == 11'd1) & crc_rec_q;
  assign crc_if.clr = start_frame;
  assign crc_if.step = zero_step | ((state == SAFT_NIB) &
    (nib_idx != 3'd0) & (nib_idx <= n_data_q) &
    (tick_in_el == 9'd0) & (div == 11'd0));
  assign crc_if.nib = zero_step ? 4'h0 : nib_q[nib_idx];

  // frame latch: contents and options frozen for the whole frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        nib_q[i] <= 4'h0;
      end
      n_data_q <= 3'd6;
      tick_cyc_q <= 11'(`SAFT_TICK_CYC(`SAFT_TICK1_US_X10));
      frame_len_q <= `SAFT_LEN_SS;
      pause_en_q <= 1'b0;
      crc_rec_q <= 1'b1;
    end else if (start_frame) begin
      nib_q[0] <= status_nib;
      for (int i = 0; i < 6; i++) begin
        nib_q[i+1] <= data_nib[i];
      end
      nib_q[7] <= 4'h0;
      n_data_q <= n_data;
      tick_cyc_q <= tick_sel_cyc;
      frame_len_q <= target_len;
      pause_en_q <= frame_settings_word[`SAFT_FS_PAUSE_EN];
      crc_rec_q <= frame_settings_word[`SAFT_FS_CRC_REC];
    end
  end

  // loop counter, one step per frame, natural 8-bit wrap
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_cnt <= 8'h00;
    end else if (start_frame) begin
      loop_cnt <= loop_cnt + 8'h01;
    end
  end

  // tick divider and tick count inside the current element
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 11'd0;
      tick_in_el <= 9'd0;
    end else if (start_frame | el_end | state == SAFT_IDLE) begin
      div <= 11'd0;
      tick_in_el <= 9'd0;
    end else if (tick_end) begin
      div <= 11'd0;
      tick_in_el <= tick_in_el + 9'd1;
    end else begin
      div <= div + 11'd1;
    end
  end

  // element sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SAFT_IDLE;
      nib_idx <= 3'd0;
      el_len <= `SAFT_SYNC_TICKS;
      frame_ticks <= 9'd0;
    end else if (start_frame) begin
      state <= SAFT_SYNC;
      nib_idx <= 3'd0;
      el_len <= `SAFT_SYNC_TICKS;
      frame_ticks <= 9'd0;
    end else if (el_end) begin
      frame_ticks <= used;
      case (state)
        SAFT_SYNC: begin
          state <= SAFT_NIB;
          nib_idx <= 3'd0;
          el_len <= `SAFT_NIB_BASE + 9'(nib_q[0]);
        end
        SAFT_NIB: begin
          if (!is_last) begin
            nib_idx <= nib_idx + 3'd1;
            el_len <= `SAFT_NIB_BASE + 9'(nxt_nib);
          end else if (pause_en_q) begin
            state <= SAFT_PAUSE;
            el_len <= pause_len;
          end else begin
            state <= SAFT_IDLE; // disabled at frame end
          end
        end
        SAFT_PAUSE: begin
          state <= SAFT_IDLE; // disabled at frame end
        end
        default: begin
          state <= SAFT_IDLE;
        end
      endcase
    end
  end

  // pin: low for the first ticks of each element, so every element
  // begins with a falling edge; a one-cycle lag is uniform and harmless
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b1;
      oe_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      pin_q <= ~((state != SAFT_IDLE) &
        (tick_in_el < `SAFT_LOW_TICKS));
      oe_q <= (state != SAFT_IDLE);
      // marks the cycle in which the sync's falling edge shows on the pin
      start_q <= (state == SAFT_SYNC) & (tick_in_el == 9'd0) &
        (div == 11'd0);
    end
  end

  assign output_data_pin_o = pin_q;
  assign output_data_pin_oe_o = oe_q;
  assign frame_start_o = start_q;
endmodule

// File: tb/saft_tx_properties.sv
`timescale 1ns/1ps
module saft_props_chk (
  input wire logic clk_sys_i,              // system clock
  input wire logic rst_n_i,                // async reset, active low
  input wire logic [4:0] avs_address_i,    // byte address
  input wire logic avs_read_i,             // read strobe
  input wire logic avs_write_i,            // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  input wire logic avs_waitrequest_o,      // stall
  input wire logic output_data_pin_o,      // frame waveform
  input wire logic output_data_pin_oe_o,   // pin driven
  input wire logic frame_start_o           // frame start pulse
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [10:0] fs;
  logic en, pin_q, sync_ph, pause_q, fix_q, prev_ok;
  logic [1:0] fmt_q;
  logic [3:0] nib_n;
  int unsigned since, fcyc, tick;
  wire acc = avs_write_i && !avs_waitrequest_o;
  wire fall = pin_q && !output_data_pin_o;
  // 297, 239, 196, 269 ticks; the latched config is the running frame's
  wire [8:0] tgt = fix_q ? 9'h129 : fmt_q == 2'h2 ? 9'h0ef :
    fmt_q == 2'h3 ? 9'h0c4 : 9'h10d;

  function automatic int unsigned tk(input logic [1:0] s);
    return s == 2'h0 ? 540 : s == 2'h1 ? 600 : s == 2'h2 ? 900 : 1200;
  endfunction

  // shadows of enable and frame settings, updated where a write lands
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs <= 11'h025;
      en <= 1'b0;
    end else if (acc) begin
      if (avs_address_i == 5'h00 && avs_byteenable_i[1])
        en <= avs_writedata_i[12];
      if (avs_address_i == 5'h04 && avs_byteenable_i[0])
        fs[7:0] <= avs_writedata_i[7:0];
      if (avs_address_i == 5'h04 && avs_byteenable_i[1])
        fs[10:8] <= avs_writedata_i[10:8];
    end
  end

  // edge timing: cycles since last fall and since last frame start
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b1;
      since <= 0;
      fcyc <= 0;
      sync_ph <= 1'b0;
      nib_n <= 4'h0;
      prev_ok <= 1'b0;
      tick <= 600;
      pause_q <= 1'b0;
      fix_q <= 1'b0;
      fmt_q <= 2'h0;
    end else begin
      pin_q <= output_data_pin_o;
      since <= fall ? 1 : since + 1;
      fcyc <= frame_start_o ? 1 : fcyc + 1;
      if (frame_start_o) begin
        sync_ph <= 1'b1;
        nib_n <= 4'h0;
        prev_ok <= 1'b1;
        tick <= tk(fs[1:0]);
        pause_q <= fs[3];
        fix_q <= fs[4];
        fmt_q <= fs[6:5];
      end else if (fall) begin
        sync_ph <= 1'b0;
        nib_n <= nib_n + 4'h1;
      end
      // a gap in sending makes the next frame length meaningless
      if (!output_data_pin_oe_o)
        prev_ok <= 1'b0;
    end
  end

  enable_gate_a: assert property (frame_start_o |-> $past(en))
    else $error("frame started while sending disabled");
  idle_high_a: assert property (!output_data_pin_oe_o |-> output_data_pin_o)
    else $error("pin not high while undriven");
  start_pulse_a: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  start_fall_a: assert property (frame_start_o |-> fall && output_data_pin_oe_o)
    else $error("frame start without falling edge");
  sync_len_a: assert property (fall && sync_ph && !frame_start_o |-> since == 56 * tick)
    else $error("sync interval wrong");
  low_pulse_a: assert property ($rose(output_data_pin_o) && output_data_pin_oe_o
    |-> since == 5 * tick)
    else $error("low pulse length wrong");
  nib_len_a: assert property (fall && !frame_start_o && !sync_ph && nib_n >= 4'h1 &&
    nib_n <= 4'h6 |-> since % tick == 0 && since >= 12 * tick && since <= 27 * tick)
    else $error("nibble interval out of range");
  frame_len_a: assert property (frame_start_o && prev_ok && pause_q
    |-> fcyc == tgt * tick || since == 12 * tick)
    else $error("frame length with pause wrong");
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer not after one cycle");
endmodule

bind saft_tx saft_props_chk u_chk (.clk_sys_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_waitrequest_o, .output_data_pin_o, .output_data_pin_oe_o,
  .frame_start_o);

// File: tb/saft_sent_rx.sv
`timescale 1ns/1ps
module saft_sent_rx #(
  parameter int TICK_NOM = 540 // nominal tick in clock cycles
) (
  input wire logic clk_sys_i,   // sampling clock
  input wire logic line_i,      // resolved line level
  output logic [3:0] nib_o [8], // status, six data, crc
  output int frames_o,          // frames decoded so far
  output int len_o              // ticks of the frame before the last sync
);
  int cnt = 0;
  int now = 0;
  int tick = TICK_NOM;
  int idx = -1;
  int last_st = -1;
  logic line_q = 1'b1;
  int frames = 0;
  int len = 0;

  // one driver per output; counters live in the sampling process
  assign frames_o = frames;
  assign len_o = len;

  // the sync is recognised near its nominal length and then measured, so
  // nibbles are decoded with the sender's real tick, not the nominal one
  always @(posedge clk_sys_i) begin
    int st;
    int t;
    now++;
    line_q <= line_i;
    cnt <= cnt + 1;
    if (line_q && !line_i) begin
      cnt <= 1;
      if (cnt > 54 * TICK_NOM && cnt < 58 * TICK_NOM) begin
        t = cnt / 56;
        st = now - cnt;
        if (last_st >= 0)
          len <= (st - last_st + t / 2) / t;
        last_st = st;
        tick <= t;
        idx <= 0;
      end else if (idx >= 0 && idx < 8) begin
        nib_o[idx] <= 4'((cnt + tick / 2) / tick - 12);
        idx <= idx + 1;
        if (idx == 7)
          frames <= frames + 1;
      end
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "saft_cfg.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] angle = 12'h000;
  logic diag = 1'b0;
  logic prewarn = 1'b0;
  logic [1:0] slow_bits = 2'h0;
  logic pin, pin_oe, frame_start;
  wire line = pin_oe ? pin : 1'b1; // line pulled up while undriven
  logic [3:0] rx_nib [8];
  int rx_frames, rx_len;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // per frame: settings, angle, {slow, prewarn, diag}, data, status, length
  logic [31:0] fs_t [4] = '{32'h02c, 32'h5bc, 32'h208, 32'h02c};
  logic [11:0] ang_t [4] = '{12'h123, 12'h100, 12'hffa, 12'hffe};
  logic [3:0] in_t [4] = '{4'hb, 4'hb, 4'hf, 4'h0};
  logic [11:0] val_t [4] = '{12'h123, 12'hef8, 12'hff8, 12'h001};
  logic [3:0] st_t [4] = '{4'h3, 4'ha, 4'h1, 4'h0};
  logic [31:0] len_t [3] = '{32'h10d, 32'h129, 32'h10d};

  saft_tx uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .angle_i(angle), .diag_i(diag),
    .prewarn_i(prewarn), .slow_bits_i(slow_bits),
    .output_data_pin_o(pin), .output_data_pin_oe_o(pin_oe),
    .frame_start_o(frame_start));
  saft_sent_rx #(.TICK_NOM(540)) rx (.clk_sys_i(clk_sys_i), .line_i(line),
    .nib_o(rx_nib), .frames_o(rx_frames), .len_o(rx_len));

  always #2.5 clk_sys_i = ~clk_sys_i;

  // the shortest tick is 540 cycles, so four frames cannot be made shorter
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 900000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one bus cycle, entered just after a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic apply(input int k);
    angle <= ang_t[k];
    {slow_bits, prewarn, diag} <= in_t[k];
  endtask

  // crc over data nibbles 1..6, plus a zero nibble when recommended
  function automatic logic [3:0] crc_of(input logic [3:0] n [8],
                                        input logic rec);
    logic [3:0] c;
    c = 4'h5;
    for (int i = 1; i < 8; i++) begin
      if (i < 7 || rec) begin
        for (int b = 0; b < 4; b++)
          c = {c[2:0], 1'b0} ^ (c[3] ? 4'hd : 4'h0);
        c = c ^ (i < 7 ? n[i] : 4'h0);
      end
    end
    return c;
  endfunction

  // main sequence: reset values, bus refusals, then four decoded frames
  initial begin
    logic [31:0] q;
    logic [3:0] e [8];
    logic [11:0] v;
    logic [7:0] lc;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk(`SAFT_ADDR_SYS, `SAFT_SYS_RST);
    rd_chk(`SAFT_ADDR_FRAME, `SAFT_FS_RST);
    rd_chk(`SAFT_ADDR_CLAMP, `SAFT_CLAMP_RST);
    rd_chk(`SAFT_ADDR_ANGLE, `SAFT_ANGLE_RST);
    bus(1'b1, 5'h14, 32'hffff_ffff, q);
    rd_chk(5'h14, 32'h0);
    bus(1'b1, `SAFT_ADDR_FRAME, fs_t[0], q);
    apply(0);
    repeat (20) @(posedge clk_sys_i);
    check(pin_oe, 1'b0);
    bus(1'b1, `SAFT_ADDR_SYS, 32'h1000, q);
    for (int k = 0; k < 4; k++) begin
      while (rx_frames <= k) @(posedge clk_sys_i);
      v = val_t[k];
      lc = 8'(k);
      e = '{st_t[k], v[11:8], v[7:4], v[3:0], lc[7:4], lc[3:0], ~v[11:8],
            4'h0};
      e[7] = crc_of(e, fs_t[k][2]);
      check(rx_nib[0], e[0]);
      for (int i = 1; i < 7; i++)
        check(rx_nib[i], e[i]);
      check(rx_nib[7], e[7]);
      if (k > 0)
        check(rx_len, len_t[k-1]);
      if (k < 3) begin
        bus(1'b1, `SAFT_ADDR_FRAME, fs_t[k+1], q);
        apply(k + 1);
      end
    end
    // sending stops only after the running frame has ended
    bus(1'b1, `SAFT_ADDR_SYS, 32'h0, q);
    while (pin_oe !== 1'b0) @(posedge clk_sys_i);
    check(rx_frames, 32'h4);
    check(line, 1'b1);
    rd_chk(`SAFT_ADDR_STAT, {18'h0, e[7], 10'h004});
    give_verdict();
  end
endmodule
